// ---- logic/mac_accumulate_and_move.sv ----
// Multiply-accumulate-and-move datapath behind an APB slave, with its own data RAM.
// Assumes an APB master on the same clock; every register runs on the rising edge.
//
// Functional notes
// - unsigned variants zero-extend the unsigned product
// - mixed variants: first unsigned, second signed
// - mixed product sign-extended to forty bits
// - additive variants add product into sum
// - subtractive variants subtract product from sum
// - rounding adds 8000h, clears low word
// - rounding acts on accumulated result
// - every variant copies indexed word in RAM
// - move happens in same instruction cycle
// - move destination is the updated index
// - additive overflow flag on forty-bit overflow
// - subtractive overflow flag on forty-bit underflow
// - sticky overflow set on overflow, else kept
// - sticky saturation set when clamped, else kept
// - guard flag set when guard bits used
// - carry flag on carry or borrow
// - zero flag when result equals zero
// - negative flag mirrors result top bit
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "mac_move_defs.svh"

module mac_accumulate_and_move
  import mac_move_pkg::*;
#(
  parameter int RAM_WORDS = 16  // Depth of the dual port RAM in words
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  localparam int AW = $clog2(RAM_WORDS);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Map a third opcode byte onto its variant; anything else is not valid
  function automatic mac_op_t decode_op(input logic [7:0] opc);
    mac_op_t d;
    d = '0;
    unique case (opc)
      `OPC_U_ADD:      d = '{1'b1, 1'b0, 1'b0, 1'b0};
      `OPC_U_ADD_RND:  d = '{1'b1, 1'b0, 1'b0, 1'b1};
      `OPC_U_SUB:      d = '{1'b1, 1'b0, 1'b1, 1'b0};
      `OPC_US_ADD:     d = '{1'b1, 1'b1, 1'b0, 1'b0};
      `OPC_US_ADD_RND: d = '{1'b1, 1'b1, 1'b0, 1'b1};
      `OPC_US_SUB:     d = '{1'b1, 1'b1, 1'b1, 1'b0};
      default:         d = '0;  // Unknown codes are refused
    endcase
    return d;
  endfunction

  // Guard bits in use when bits 39..31 are not all copies of the sign
  function automatic logic guard_used(input logic [39:0] v);
    return !((&v[39:31]) || !(|v[39:31]));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic [15:0] ram [RAM_WORDS];  // Dual port RAM, one word per entry
  logic [39:0] sum_reg;          // mac_sum_register: guard byte over two words
  logic [7:0]  flags_reg;        // MAC flags
  logic [1:0]  control_reg;      // Saturation enable, index direction
  logic [7:0]  opcode_reg;       // Last third opcode byte issued
  logic [AW-1:0] index_pointer_reg;  // Index pointer into the RAM
  logic [AW-1:0] operand_ptr_reg;    // Second operand pointer
  logic        ack_reg;          // Second access cycle of a transfer
  logic [31:0] prdata_reg;       // Registered read data

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire access      = psel && penable;
  wire take        = access && ack_reg;  // Edge where the transfer completes
  wire wr_take     = take && pwrite;
  wire ram_hit     = (paddr[11:8] == `RAM_PAGE) && (paddr[1:0] == 2'h0)
                     && ({26'h0, paddr[7:2]} < 32'(RAM_WORDS));
  wire [AW-1:0] ram_addr = paddr[AW+1:2];
  wire hit_opcode  = (paddr == `OFS_OPCODE);
  wire hit_ptrs    = (paddr == `OFS_POINTERS);
  wire hit_ctrl    = (paddr == `OFS_CONTROL);
  wire hit_low     = (paddr == `OFS_SUM_LOW);
  wire hit_guard   = (paddr == `OFS_SUM_GUARD);
  wire hit_flags   = (paddr == `OFS_FLAGS);
  wire addr_hit    = ram_hit || hit_opcode || hit_ptrs || hit_ctrl
                     || hit_low || hit_guard || hit_flags;
  // Writing the opcode register issues one instruction
  wire     issue     = wr_take && hit_opcode;
  mac_op_t op;
  assign   op        = decode_op(pwdata[7:0]);
  wire     exec      = issue && op.valid;

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic

  // Both operand reads happen in the issue cycle
  wire [15:0] op_a = ram[index_pointer_reg];
  wire [15:0] op_b = ram[operand_ptr_reg];
  wire signed [32:0] prod_mixed = $signed({1'b0, op_a}) * $signed(op_b);
  wire [31:0] prod_u = op_a * op_b;
  // Extension to forty bits: mixed sign-extends the signed product, unsigned zero-fills the guard byte
  wire [39:0] prod_ext = op.mixed ? {{8{prod_mixed[31]}}, prod_mixed[31:0]}
                                  : {8'h00, prod_u};
  wire [39:0] rnd_add  = op.rnd ? `ROUND_CONST : 40'h0;
  // Forty-one bits catch the carry or borrow; signed range excess is judged below
  wire [40:0] raw = op.sub ? ({1'b0, sum_reg} - {1'b0, prod_ext})
                           : ({1'b0, sum_reg} + {1'b0, prod_ext}
                              + {1'b0, rnd_add});
  wire [39:0] raw40 = raw[39:0];
  // Signed range excess from operand and result sign bits
  wire ovf = op.sub
             ? (sum_reg[39] != prod_ext[39]) && (raw40[39] != sum_reg[39])
             : (sum_reg[39] == prod_ext[39]) && (raw40[39] != sum_reg[39]);
  // Rounded results lose their low word
  wire [39:0] rounded = op.rnd ? {raw40[39:16], 16'h0000} : raw40;
  wire sat_en = control_reg[`CTL_SAT_EN];
  wire do_sat = sat_en && ovf;
  // Clamp toward the sign of the true result, the sign of the old sum
  wire [39:0] result = do_sat ? (sum_reg[39] ? `SAT_MIN : `SAT_MAX)
                              : rounded;

  // Flags that follow the result
  logic [7:0] flags_next;
  always_comb begin
    flags_next = flags_reg;
    // Software clears sticky bits by writing one; a set below wins
    if (wr_take && hit_flags) begin
      flags_next[`FLG_STK_SAT] = flags_reg[`FLG_STK_SAT] & ~pwdata[`FLG_STK_SAT];
      flags_next[`FLG_STK_OVF] = flags_reg[`FLG_STK_OVF] & ~pwdata[`FLG_STK_OVF];
      flags_next[`FLG_BAD_OP]  = flags_reg[`FLG_BAD_OP] & ~pwdata[`FLG_BAD_OP];
    end
    if (exec) begin
      flags_next[`FLG_OVF]   = ovf;
      flags_next[`FLG_GUARD] = guard_used(result);
      flags_next[`FLG_CARRY] = raw[40];
      flags_next[`FLG_ZERO]  = (result == 40'h0);
      flags_next[`FLG_NEG]   = result[39];
      if (ovf) begin
        flags_next[`FLG_STK_OVF] = 1'b1;
      end
      if (do_sat) begin
        flags_next[`FLG_STK_SAT] = 1'b1;
      end
    end
    if (issue && !op.valid) begin
      flags_next[`FLG_BAD_OP] = 1'b1;  // Refused opcode leaves the datapath alone
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Move step

  // Destination is the pointer after its update, one word up or down
  wire [AW-1:0] index_next = control_reg[`CTL_IDX_DEC]
                             ? AW'(index_pointer_reg - 1'b1)
                             : AW'(index_pointer_reg + 1'b1);

  // RAM: bus writes, or the move in the issue cycle; both never coincide
  always_ff @(posedge clock) begin
    if (exec) begin
      ram[index_next] <= op_a;
    end else if (wr_take && ram_hit) begin
      ram[ram_addr] <= pwdata[15:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  // Accumulator, pointers and configuration
  always_ff @(posedge clock) begin
    if (rst) begin
      sum_reg           <= `RST_SUM;
      flags_reg         <= `RST_FLAGS;
      control_reg       <= `RST_CONTROL;
      opcode_reg        <= 8'h00;
      index_pointer_reg <= '0;
      operand_ptr_reg   <= '0;
    end else begin
      flags_reg <= flags_next;
      if (exec) begin
        sum_reg           <= result;
        index_pointer_reg <= index_next;
      end
      if (issue) begin
        opcode_reg <= pwdata[7:0];
      end
      if (wr_take && hit_low) begin
        sum_reg[31:0] <= pwdata;
      end
      if (wr_take && hit_guard) begin
        sum_reg[39:32] <= pwdata[7:0];
      end
      if (wr_take && hit_ctrl) begin
        control_reg <= pwdata[1:0];
      end
      if (wr_take && hit_ptrs) begin
        index_pointer_reg <= pwdata[AW-1:0];
        operand_ptr_reg   <= pwdata[AW+15:16];
      end
    end
  end

  // Read data mux for the first access cycle
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0;
    if (ram_hit) begin
      rd_mux = {16'h0, ram[ram_addr]};
    end else if (hit_opcode) begin
      rd_mux = {24'h0, opcode_reg};
    end else if (hit_ptrs) begin
      rd_mux = {16'(operand_ptr_reg), 16'(index_pointer_reg)};
    end else if (hit_ctrl) begin
      rd_mux = {30'h0, control_reg};
    end else if (hit_low) begin
      rd_mux = sum_reg[31:0];
    end else if (hit_guard) begin
      rd_mux = {24'h0, sum_reg[39:32]};
    end else if (hit_flags) begin
      rd_mux = {24'h0, flags_reg};
    end
  end

  // One wait state: data is captured on the same edge that raises ready
  always_ff @(posedge clock) begin
    if (rst) begin
      ack_reg    <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      ack_reg <= access && !ack_reg;
      if (access && !ack_reg) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = ack_reg;
  assign pslverr = ack_reg && !addr_hit;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  // Sign-extended references, so overflow is judged apart from the datapath's own test
  wire [40:0] chk_add = {sum_reg[39], sum_reg} + {prod_ext[39], prod_ext};
  wire [40:0] chk_sub = {sum_reg[39], sum_reg} - {prod_ext[39], prod_ext};

  property p_unsigned_add;
    @(posedge clock) disable iff (rst)
    exec && !op.mixed && !op.sub && !op.rnd && !sat_en
    |=> sum_reg == $past(sum_reg) + {8'h00, 32'($past(op_a)) * 32'($past(op_b))};
  endproperty
  a_unsigned_add: assert property (p_unsigned_add)
    else $error("unsigned add wrong");

  property p_mixed_sub;
    @(posedge clock) disable iff (rst)
    exec && op.mixed && op.sub && !sat_en
    |=> $signed(sum_reg) == $signed($past(sum_reg))
        - $signed({1'b0, $past(op_a)}) * $signed($past(op_b));
  endproperty
  a_mixed_sub: assert property (p_mixed_sub)
    else $error("mixed subtract wrong");

  property p_round_low;
    @(posedge clock) disable iff (rst)
    exec && op.rnd && !sat_en |=> sum_reg[15:0] == 16'h0000;
  endproperty
  a_round_low: assert property (p_round_low)
    else $error("round left low word");

  property p_move;
    @(posedge clock) disable iff (rst)
    exec |=> ram[index_pointer_reg] == $past(op_a)
             && index_pointer_reg == $past(index_next);
  endproperty
  a_move: assert property (p_move)
    else $error("move step wrong");

  property p_sticky_ovf;
    @(posedge clock) disable iff (rst)
    exec |=> flags_reg[`FLG_STK_OVF] == ($past(ovf) || $past(flags_reg[`FLG_STK_OVF]));
  endproperty
  a_sticky_ovf: assert property (p_sticky_ovf)
    else $error("sticky overflow lost");

  property p_sat_clamp;
    @(posedge clock) disable iff (rst)
    exec && sat_en && ovf
    |=> (sum_reg == `SAT_MAX || sum_reg == `SAT_MIN) && flags_reg[`FLG_STK_SAT];
  endproperty
  a_sat_clamp: assert property (p_sat_clamp)
    else $error("saturation not applied");

  property p_zero_neg;
    @(posedge clock) disable iff (rst)
    exec |=> flags_reg[`FLG_ZERO] == (sum_reg == 40'h0)
             && flags_reg[`FLG_NEG] == sum_reg[39];
  endproperty
  a_zero_neg: assert property (p_zero_neg)
    else $error("zero or negative flag wrong");

  property p_guard;
    @(posedge clock) disable iff (rst)
    exec |=> flags_reg[`FLG_GUARD] == (sum_reg[39:31] != 9'h000 && sum_reg[39:31] != 9'h1ff);
  endproperty
  a_guard: assert property (p_guard)
    else $error("guard flag wrong");

  property p_carry;
    @(posedge clock) disable iff (rst)
    exec && op.sub |=> flags_reg[`FLG_CARRY] == ($past(sum_reg) < $past(prod_ext));
  endproperty
  a_carry: assert property (p_carry)
    else $error("borrow flag wrong");

  property p_add_ovf;
    @(posedge clock) disable iff (rst)
    exec && !op.sub && !op.rnd
    |=> flags_reg[`FLG_OVF] == $past(chk_add[40] != chk_add[39]);
  endproperty
  a_add_ovf: assert property (p_add_ovf)
    else $error("add overflow flag wrong");

  property p_sub_ovf;
    @(posedge clock) disable iff (rst)
    exec && op.sub
    |=> flags_reg[`FLG_OVF] == $past(chk_sub[40] != chk_sub[39]);
  endproperty
  a_sub_ovf: assert property (p_sub_ovf)
    else $error("subtract overflow flag wrong");

  property p_bad_op;
    @(posedge clock) disable iff (rst)
    issue && !op.valid
    |=> sum_reg == $past(sum_reg) && flags_reg[`FLG_BAD_OP];
  endproperty
  a_bad_op: assert property (p_bad_op)
    else $error("refused opcode changed the sum");

  c_round:  cover property (@(posedge clock) disable iff (rst) exec && op.rnd);
  c_sat:    cover property (@(posedge clock) disable iff (rst) exec && do_sat);
  c_bad_op: cover property (@(posedge clock) disable iff (rst) issue && !op.valid);
  c_msub:   cover property (@(posedge clock) disable iff (rst) exec && op.mixed && op.sub);

endmodule

// ---- logic/mac_move_defs.svh ----
// Constants for the multiply-accumulate-and-move datapath.
// Assumes inclusion by bare name from the package and the datapath module.
`ifndef MAC_MOVE_DEFS_SVH
`define MAC_MOVE_DEFS_SVH
// Register byte offsets on the APB bus
`define OFS_OPCODE     12'h000
`define OFS_POINTERS   12'h004
`define OFS_CONTROL    12'h008
`define OFS_SUM_LOW    12'h00c
`define OFS_SUM_GUARD  12'h010
`define OFS_FLAGS      12'h014
`define RAM_PAGE       4'h1
// Flag register bit positions
`define FLG_OVF        0
`define FLG_STK_SAT    1
`define FLG_GUARD      2
`define FLG_STK_OVF    3
`define FLG_CARRY      4
`define FLG_ZERO       5
`define FLG_NEG        6
`define FLG_BAD_OP     7
// Control register bit positions
`define CTL_SAT_EN     0
`define CTL_IDX_DEC    1
// Reset values
`define RST_SUM        40'h00_0000_0000
`define RST_FLAGS      8'h00
`define RST_CONTROL    2'h0
// Arithmetic constants
`define ROUND_CONST    40'h00_0000_8000
`define SAT_MAX        40'h7f_ffff_ffff
`define SAT_MIN        40'h80_0000_0000
// Third opcode byte of the move variants
`define OPC_U_ADD      8'h18
`define OPC_U_ADD_RND  8'h19
`define OPC_U_SUB      8'h28
`define OPC_US_ADD     8'h98
`define OPC_US_ADD_RND 8'h99
`define OPC_US_SUB     8'ha8
`endif

// ---- logic/mac_move_pkg.sv ----
// Types shared by the multiply-accumulate-and-move datapath.
// Assumes the defs header sits beside it on the include path.
`include "mac_move_defs.svh"
package mac_move_pkg;
  // Decoded instruction variant
  typedef struct packed {
    logic valid;  // Opcode is one of the move variants
    logic mixed;  // Second operand signed
    logic sub;    // Subtract product from the sum
    logic rnd;    // Round and clear the low word
  } mac_op_t;
endpackage

// ---- sim/core_issue_model.sv ----
// APB master standing in for the core that issues move instructions.
// Assumes the datapath answers on the same clock; the bench calls xfer.
`timescale 1ns/1ps
`include "mac_move_defs.svh"
module core_issue_model (
  input  wire logic        clock,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata
);
  ////////////////////////////////////////
  // Third opcode bytes; the leading byte 93 and the selectors are implied
  logic [7:0] opcodes [6];

  // Opcode table and an idle bus at time zero
  initial begin
    opcodes[0] = `OPC_U_ADD;
    opcodes[1] = `OPC_U_ADD_RND;
    opcodes[2] = `OPC_U_SUB;
    opcodes[3] = `OPC_US_ADD;
    opcodes[4] = `OPC_US_ADD_RND;
    opcodes[5] = `OPC_US_SUB;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
  end

  ////////////////////////////////////////
  // One transfer; the answer is taken at the edge where pready is high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Values seen here are those sampled at the edge, before its updates
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Released lines show the inverse, so a stale value never passes
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ---- sim/mac_accumulate_and_move_tb_top.sv ----
// Self-checking bench for the multiply-accumulate-and-move datapath.
// Assumes the APB master model beside it; one clock, 25 MHz.
`timescale 1ns/1ps
`include "mac_move_defs.svh"
module mac_accumulate_and_move_tb_top
  import mac_move_pkg::*;
;
  logic        clock;   // Bus clock
  logic        rst;     // Synchronous reset
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  int          n_mismatch;
  int          n_compared;

  ////////////////////////////////////////
  // 40 ns period
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  mac_accumulate_and_move dut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  core_issue_model core (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  ////////////////////////////////////////
  task automatic report_and_stop();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    core.xfer(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    core.xfer(1'b0, a, 32'h0, q, e);
  endtask

  ////////////////////////////////////////
  // Expected {flags, sum}; overflow counts the rounding constant, as the datapath does
  function automatic logic [47:0] model(input logic [39:0] s, input logic [15:0] a,
                                        input logic [15:0] b, input logic [7:0] opc,
                                        input logic sat);
    logic [31:0] p;
    logic [39:0] e;
    logic [39:0] r;
    logic [40:0] w;
    logic        ov;
    p = opc[7] ? {16'h0, a} * {{16{b[15]}}, b} : {16'h0, a} * {16'h0, b};
    e = opc[7] ? {{8{p[31]}}, p} : {8'h0, p};
    if (opc[5]) begin
      w = {1'b0, s} - {1'b0, e};
      ov = (s[39] != e[39]) && (w[39] != s[39]);
    end else begin
      w = {1'b0, s} + {1'b0, e} + (opc[0] ? 41'h8000 : 41'h0);
      ov = (s[39] == e[39]) && (w[39] != s[39]);
    end
    r = w[39:0];
    if (opc[0]) r[15:0] = 16'h0;
    if (sat && ov) r = s[39] ? `SAT_MIN : `SAT_MAX;
    return {1'b0, r[39], r == 40'h0, w[40], ov, r[39:31] != {9{r[39]}}, sat && ov, ov,
            r};
  endfunction

  ////////////////////////////////////////
  // Load operands, issue one instruction, read back sum, flags, moved word and index
  task automatic run_op(input logic [39:0] s, input logic [15:0] a, input logic [15:0] b,
                        input logic [7:0] opc, input logic [1:0] ctl, input logic [3:0] idx);
    logic [3:0]  nx;
    logic [47:0] x;
    logic [31:0] q;
    nx = ctl[1] ? idx - 4'h1 : idx + 4'h1;
    x = model(s, a, b, opc, ctl[0]);
    wr(`OFS_CONTROL, {30'h0, ctl});
    wr(`OFS_POINTERS, {12'h0, idx + 4'h8, 12'h0, idx});
    wr(12'h100 + {6'h0, idx, 2'h0}, {16'h0, a});
    wr(12'h100 + {6'h0, idx + 4'h8, 2'h0}, {16'h0, b});
    wr(`OFS_SUM_LOW, s[31:0]);
    wr(`OFS_SUM_GUARD, {24'h0, s[39:32]});
    // Clear the sticky and bad-opcode bits so the flags are exact
    wr(`OFS_FLAGS, 32'h8a);
    wr(`OFS_OPCODE, {24'h0, opc});
    rd(`OFS_SUM_LOW, q);
    chk(q, x[31:0]);
    rd(`OFS_SUM_GUARD, q);
    chk({24'h0, q[7:0]}, {24'h0, x[39:32]});
    rd(`OFS_FLAGS, q);
    chk({24'h0, q[7:0]}, {24'h0, x[47:40]});
    rd(12'h100 + {6'h0, nx, 2'h0}, q);
    chk(q, {16'h0, a});
    rd(`OFS_POINTERS, q);
    chk({28'h0, q[3:0]}, {28'h0, nx});
  endtask

  ////////////////////////////////////////
  // Main sequence: reset values, unmapped access, corner cases, random mix, refusal
  initial begin
    logic [31:0] q;
    logic        e;
    n_mismatch = 0;
    n_compared = 0;
    rst = 1'b1;
    void'($urandom(32'hd36753eb));
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    for (int i = 1; i < 6; i++) begin
      rd(12'(4 * i), q);
      chk(q, 32'h0);
    end
    // Unmapped place answers with an error and zero
    core.xfer(1'b0, 12'h0f0, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    run_op(`SAT_MAX, 16'hffff, 16'hffff, `OPC_U_ADD, 2'b00, 4'hf);
    run_op(`SAT_MAX, 16'hffff, 16'hffff, `OPC_U_ADD, 2'b01, 4'h0);
    run_op(40'h0, 16'h1, 16'h1, `OPC_U_SUB, 2'b10, 4'h0);
    run_op(40'h0, 16'h0, 16'h5, `OPC_US_ADD, 2'b00, 4'h3);
    run_op(40'h7fff, 16'h1, 16'h1, `OPC_US_ADD_RND, 2'b00, 4'h5);
    run_op(`SAT_MIN, 16'h1, 16'hffff, `OPC_US_ADD, 2'b01, 4'h9);
    run_op(40'h0, 16'hffff, 16'h8000, `OPC_US_SUB, 2'b00, 4'h7);
    for (int i = 0; i < 150; i++) begin
      run_op({8'($urandom), 32'($urandom)}, 16'($urandom), 16'($urandom),
             core.opcodes[$urandom % 6], 2'($urandom), 4'($urandom));
    end
    // Unknown opcode leaves the sum alone and raises bad-opcode
    wr(`OFS_SUM_LOW, 32'h1234);
    wr(`OFS_OPCODE, 32'h55);
    rd(`OFS_FLAGS, q);
    chk({31'h0, q[7]}, 32'h1);
    rd(`OFS_SUM_LOW, q);
    chk(q, 32'h1234);
    // The refused code is still recorded
    rd(`OFS_OPCODE, q);
    chk(q, 32'h55);
    report_and_stop();
  end

  // Watchdog: far beyond the roughly 8000 cycles the tests take
  initial begin
    #(40 * 30000);
    n_mismatch++;
    report_and_stop();
  end
endmodule
